/* File: hdl/cdcal_core.sv */
// Purpose: Coarse delay calibration: position memory, APB registers,
//          automatic coarse search and delay hand-off.
// Assumes: Fine-pass logic on pclk feeds fine_wr / fine_done.
// Notes:   Memory is reachable over APB only while idle or halted.
`timescale 1ns/1ps
// Summary of operation
// (R1) Positions 0..2239; top bits give cycle index
// (R2) Aligned delays must fit a 16-cycle window
// (R3) Fine pass stores twelve-bit positions, twelve entries
// (R4) After fine pass, continue or halt per flag
// (R5) Halted: host reads and rewrites position memory
// (R6) Host starts all devices in same cycle
// (R7) First step: value becomes 3200 minus position
// (R8) Add sample offset, then XOR with 31
// (R9) Subtract 32 with wrap until aligned
// (R10) Send low nine bits to delay chips
// (R11) Bit 13 clear: entry ignored by search
// (R12) Host should preload entries with 4096
// (R13) Abort after 8192 cycles, send nothing
// (R14) Host loads sample offset by dedicated command
// (R15) Status shows last run succeeded or aborted
module cdcal_core
   import cdcal_pkg::*;
#(
   parameter int ABORT_LIMIT = ABORT_CYCLES
) (
   // Clock and reset.
   input  wire logic              pclk,
   input  wire logic              presetn,
   // APB slave.
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Fine-pass side.
   output logic                   fine_start,
   input  wire logic              fine_wr,
   input  wire logic [3:0]        fine_chan,
   input  wire logic [11:0]       fine_pos,
   input  wire logic              fine_done,
   // Delay chip pins.
   output logic                   dly_strobe,
   output logic [3:0]             dly_chan,
   output logic [cdcal_pkg::OUT_W-1:0] dly_value,
   input  wire logic              dly_busy,
   // Interrupt.
   output logic                   irq
);
   import cdcal_pkg::*;

   // ==========================================================
   // State
   cdcal_state_e     st_r;
   logic [13:0]      mem_r   [NCH];
   logic [12:0]      work_r  [NCH];
   logic [NCH-1:0]   valid_r;
   logic [13:0]      cnt_r;
   logic             cont_r;
   logic [11:0]      offset_r;
   logic             start_r;
   logic             last_ok_r;
   logic             last_abort_r;
   logic [2:0]       irq_stat_r;
   logic [2:0]       irq_en_r;
   logic [2:0]       irq_set;
   logic [2:0]       irq_clr;

   cdcal_dly_if      dl ();

   // ==========================================================
   // APB decode
   logic             acc_wr;
   logic             mem_sel;
   logic [3:0]       mem_idx;
   logic             mem_open;
   logic             reg_hit;

   assign acc_wr   = psel & penable & pready & pwrite;
   assign mem_idx  = paddr[5:2];
   assign mem_sel  = (paddr[7:6] == MEM_PAGE) && (paddr[1:0] == 2'h0)
                     && (mem_idx < 4'(NCH));
   assign mem_open = (st_r == CDCAL_IDLE) || (st_r == CDCAL_HALT); // R5
   assign reg_hit  = (paddr == CTRL_OFF) || (paddr == OFFSET_OFF)
                     || (paddr == STATUS_OFF) || (paddr == IRQ_STAT_OFF)
                     || (paddr == IRQ_EN_OFF) || (paddr == IRQ_CLR_OFF)
                     || mem_sel;

   // Answer is prepared in the setup cycle, so every access has no wait.
   // Only unmapped addresses raise pslverr; refused writes are
   // dropped quietly and refused memory reads return zero.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel & ~penable & ~pready;
         pslverr <= psel & ~penable & ~pready & ~reg_hit;
         if (psel & ~penable & ~pready) begin
            prdata <= 32'h0000_0000;
            if (!pwrite) begin
               case (paddr)
                  CTRL_OFF:     prdata <= {30'h0, cont_r, 1'b0};
                  OFFSET_OFF:   prdata <= {20'h0, offset_r};
                  STATUS_OFF:   prdata <= {26'h0, last_abort_r, last_ok_r, // R15
                                          1'b0, st_r};
                  IRQ_STAT_OFF: prdata <= {29'h0, irq_stat_r};
                  IRQ_EN_OFF:   prdata <= {29'h0, irq_en_r};
                  default: begin
                     if (mem_sel && mem_open) begin
                        // Word plus the cycle index of its position.
                        prdata <= {9'h0,
                                   7'(mem_r[mem_idx][11:0] >> CYC_SHIFT), // R1
                                   2'h0, mem_r[mem_idx]};
                     end
                  end
               endcase
            end
         end
      end
   end

   // ==========================================================
   // Control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cont_r   <= 1'b0;
         offset_r <= OFFSET_RESET;
         start_r  <= 1'b0;
         irq_en_r <= 3'h0;
      end else begin
         // Start is a pulse; the sequencer takes it only when idle
         // or halted, so a stray write cannot restart a run.
         start_r <= 1'b0;
         if (acc_wr && paddr == CTRL_OFF) begin
            cont_r  <= pwdata[CONT_BIT];
            start_r <= pwdata[START_BIT]; // R6
         end
         if (acc_wr && paddr == OFFSET_OFF && mem_open) begin
            offset_r <= pwdata[11:0]; // R14
         end
         if (acc_wr && paddr == IRQ_EN_OFF) begin
            irq_en_r <= pwdata[2:0];
         end
      end
   end

   // ==========================================================
   // Interrupts: a set in the same cycle as a clear wins.
   // The output uses the next status value, so irq moves in the
   // same cycle as the status bit.
   assign irq_clr = (acc_wr && paddr == IRQ_CLR_OFF) ? pwdata[2:0] : 3'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_r <= 3'h0;
         irq        <= 1'b0;
      end else begin
         irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
         irq        <= |(((irq_stat_r & ~irq_clr) | irq_set) & irq_en_r);
      end
   end

   // ==========================================================
   // Position memory
   // The fine pass writes only in FINE and the bus only when
   // idle or halted, so the two writers never meet.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NCH; i++) begin
            mem_r[i] <= MEM_RESET;
         end
      end else if (st_r == CDCAL_FINE) begin
         if (fine_wr && fine_chan < 4'(NCH)) begin
            // Out-of-range positions are stored but flagged unusable.
            mem_r[fine_chan] <= {mem_r[fine_chan][VALID_BIT] // R3
                                 & ({1'b0, fine_pos} <= POS_MAX), // R1
                                 1'b0, fine_pos};
         end
      end else if (acc_wr && mem_sel && mem_open) begin
         mem_r[mem_idx] <= pwdata[13:0]; // R5
      end
   end

   // ==========================================================
   // Per-channel arithmetic
   // Each value becomes (3200 - pos + offset) with its low five
   // bits inverted, is folded into one period, then stepped down
   // one cycle at a time. Invalid entries are not folded; they are
   // stepped as well but never decide when the search stops.
   logic [NCH-1:0]   zero_hit;
   logic [NCH-1:0]   in_range;
   logic [NCH-1:0]   over;
   logic [12:0]      prep_v [NCH];
   logic [12:0]      norm_v [NCH];
   logic [12:0]      step_v [NCH];

   for (genvar g = 0; g < NCH; g++) begin : g_ch
      assign prep_v[g]   = (13'(NEG_BASE - {1'b0, mem_r[g][11:0]}) // R7
                            + {1'b0, offset_r}) ^ LOW_MASK; // R8
      assign over[g]     = valid_r[g] && (work_r[g] > POS_MAX);
      assign norm_v[g]   = over[g] ? work_r[g] - PERIOD : work_r[g];
      assign step_v[g]   = (work_r[g] < STEP) ? work_r[g] + PERIOD - STEP // R9
                                              : work_r[g] - STEP;
      assign zero_hit[g] = valid_r[g] && (work_r[g] == 13'h0000);
      assign in_range[g] = !valid_r[g] || (work_r[g] < RANGE_LIMIT); // R2
      assign dl.value[g] = work_r[g][OUT_W-1:0]; // R10
   end

   assign dl.mask = valid_r;

   // ==========================================================
   // Sequencer
   // The counter runs while folding or searching, so the limit
   // covers the whole search. With no valid entry the run gives
   // up at once.
   logic solved;
   logic timeout;

   assign solved  = (|zero_hit) && (&in_range); // R9
   assign timeout = (cnt_r == 14'(ABORT_LIMIT - 1)); // R13

   always_comb begin
      irq_set = 3'h0;
      if (st_r == CDCAL_FINE && fine_done && !cont_r) begin
         irq_set[IRQ_HALT] = 1'b1;
      end
      if (st_r == CDCAL_SEND && dl.done) begin
         irq_set[IRQ_DONE] = 1'b1;
      end
      if ((st_r == CDCAL_PREP && mem_valid_none()) ||
          ((st_r == CDCAL_NORM || st_r == CDCAL_SEARCH) && timeout && !solved)) begin
         irq_set[IRQ_ABORT] = 1'b1;
      end
   end

   function automatic logic mem_valid_none();
      logic any;
      any = 1'b0;
      for (int i = 0; i < NCH; i++) begin
         any = any | mem_r[i][VALID_BIT];
      end
      return !any;
   endfunction

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r         <= CDCAL_IDLE;
         cnt_r        <= 14'h0000;
         valid_r      <= '0;
         last_ok_r    <= 1'b0;
         last_abort_r <= 1'b0;
         fine_start   <= 1'b0;
         dl.go        <= 1'b0;
         for (int i = 0; i < NCH; i++) begin
            work_r[i] <= 13'h0000;
         end
      end else begin
         fine_start <= 1'b0;
         dl.go      <= 1'b0;
         if (st_r == CDCAL_NORM || st_r == CDCAL_SEARCH) begin
            cnt_r <= cnt_r + 14'h0001;
         end
         case (st_r)
            CDCAL_IDLE, CDCAL_HALT: begin
               if (start_r) begin
                  fine_start <= 1'b1;
                  st_r       <= CDCAL_FINE;
               end
            end
            CDCAL_FINE: begin
               if (fine_done) begin
                  st_r <= cont_r ? CDCAL_PREP : CDCAL_HALT; // R4
               end
            end
            CDCAL_PREP: begin
               cnt_r <= 14'h0000;
               for (int i = 0; i < NCH; i++) begin
                  valid_r[i] <= mem_r[i][VALID_BIT]; // R11
                  work_r[i]  <= prep_v[i];
               end
               if (mem_valid_none()) begin
                  last_ok_r    <= 1'b0;
                  last_abort_r <= 1'b1;
                  st_r         <= CDCAL_IDLE;
               end else begin
                  st_r <= CDCAL_NORM;
               end
            end
            CDCAL_NORM: begin
               // Bring every valid value into one period before stepping.
               for (int i = 0; i < NCH; i++) begin
                  work_r[i] <= norm_v[i];
               end
               if (timeout) begin
                  last_ok_r    <= 1'b0;
                  last_abort_r <= 1'b1;
                  st_r         <= CDCAL_IDLE;
               end else if (!(|over)) begin
                  st_r <= CDCAL_SEARCH;
               end
            end
            CDCAL_SEARCH: begin
               if (solved) begin
                  dl.go <= 1'b1;
                  st_r  <= CDCAL_SEND;
               end else if (timeout) begin
                  last_ok_r    <= 1'b0; // R13
                  last_abort_r <= 1'b1;
                  st_r         <= CDCAL_IDLE;
               end else begin
                  for (int i = 0; i < NCH; i++) begin
                     work_r[i] <= step_v[i];
                  end
               end
            end
            CDCAL_SEND: begin
               if (dl.done) begin
                  last_ok_r    <= 1'b1; // R15
                  last_abort_r <= 1'b0;
                  st_r         <= CDCAL_IDLE;
               end
            end
            default: st_r <= CDCAL_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Delay chip sender
   // Channels are sent in order, invalid ones skipped; done comes
   // once the last channel is sent or skipped.
   cdcal_dly_tx u_tx (
      .pclk       (pclk),
      .presetn    (presetn),
      .dl         (dl.xmit),
      .dly_strobe (dly_strobe),
      .dly_chan   (dly_chan),
      .dly_value  (dly_value),
      .dly_busy   (dly_busy)
   );
endmodule // cdcal_core

/* File: hdl/cdcal_dly_if.sv */
// Purpose: Carries final delays from the calibration core to the sender.
// Assumes: Both ends on pclk.
// Notes:   go is a one-cycle pulse; values and mask hold until done.
`timescale 1ns/1ps
interface cdcal_dly_if;
   import cdcal_pkg::*;
   logic                go;
   logic [NCH-1:0]      mask;
   logic [OUT_W-1:0]    value [NCH];
   logic                done;
   modport ctrl (output go, output mask, output value, input done);
   modport xmit (input go, input mask, input value, output done);
endinterface

/* File: hdl/cdcal_dly_tx.sv */
// Purpose: Sends each valid channel's delay to the external delay chips.
// Assumes: dly_busy comes from a pin and is synchronised here.
// Notes:   A fixed gap after each strobe covers the synchroniser latency.
`timescale 1ns/1ps
module cdcal_dly_tx
   import cdcal_pkg::*;
(
   // Clock and reset.
   input  wire logic          pclk,
   input  wire logic          presetn,
   // Core side.
   cdcal_dly_if.xmit          dl,
   // Delay chip pins.
   output logic               dly_strobe,
   output logic [3:0]         dly_chan,
   output logic [OUT_W-1:0]   dly_value,
   input  wire logic          dly_busy
);
   // ==========================================================
   // Busy synchroniser and sequencer
   logic       busy_m_r, busy_s_r;
   cdcal_tx_e  st_r;
   logic [3:0] idx_r;
   logic [1:0] gap_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_m_r <= 1'b0;
         busy_s_r <= 1'b0;
      end else begin
         busy_m_r <= dly_busy;
         busy_s_r <= busy_m_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r       <= TX_IDLE;
         idx_r      <= 4'h0;
         gap_r      <= 2'h0;
         dly_strobe <= 1'b0;
         dly_chan   <= 4'h0;
         dly_value  <= '0;
         dl.done    <= 1'b0;
      end else begin
         dly_strobe <= 1'b0;
         dl.done    <= 1'b0;
         case (st_r)
            TX_IDLE: begin
               idx_r <= 4'h0;
               if (dl.go) begin
                  st_r <= TX_CHECK;
               end
            end
            TX_CHECK: begin
               if (!dl.mask[idx_r]) begin
                  if (idx_r == 4'(NCH - 1)) begin
                     dl.done <= 1'b1;
                     st_r    <= TX_IDLE;
                  end
                  idx_r <= idx_r + 4'h1;
               end else if (!busy_s_r) begin
                  dly_strobe <= 1'b1; // R10
                  dly_chan   <= idx_r;
                  dly_value  <= dl.value[idx_r];
                  gap_r      <= 2'(TX_GAP);
                  st_r       <= TX_GAP_ST;
               end
            end
            TX_GAP_ST: begin
               if (gap_r != 2'h0) begin
                  gap_r <= gap_r - 2'h1;
               end else if (idx_r == 4'(NCH - 1)) begin
                  dl.done <= 1'b1;
                  st_r    <= TX_IDLE;
               end else begin
                  idx_r <= idx_r + 4'h1;
                  st_r  <= TX_CHECK;
               end
            end
            default: st_r <= TX_IDLE;
         endcase
      end
   end
endmodule // cdcal_dly_tx

/* File: hdl/cdcal_pkg.sv */
// Purpose: Shared constants and types of the coarse delay calibration block.
// Assumes: One 200 MHz clock, APB register access.
// Notes:   Positions are in 1/32 cycle units within a 70-cycle period.
package cdcal_pkg;
   // ==========================================================
   // Sizes and arithmetic constants
   localparam int              NCH           = 12;
   localparam int              VALID_BIT     = 13;
   localparam int              CYC_SHIFT     = 5;
   localparam int              OUT_W         = 9;
   localparam int              RANGE_CYCLES  = 16;
   localparam int              ABORT_CYCLES  = 8192;
   localparam logic [12:0]     POS_MAX       = 13'h08BF;
   localparam logic [12:0]     PERIOD        = 13'h08C0;
   localparam logic [12:0]     NEG_BASE      = 13'h0C80;
   localparam logic [12:0]     STEP          = 13'h0020;
   localparam logic [12:0]     LOW_MASK      = 13'h001F;
   localparam logic [12:0]     RANGE_LIMIT   = 13'(RANGE_CYCLES * 32);
   localparam logic [13:0]     MEM_RESET     = 14'h1000;
   localparam int              TX_GAP        = 3;
   // ==========================================================
   // Register map (byte addresses)
   localparam logic [7:0]      CTRL_OFF      = 8'h00;
   localparam logic [7:0]      OFFSET_OFF    = 8'h04;
   localparam logic [7:0]      STATUS_OFF    = 8'h08;
   localparam logic [7:0]      IRQ_STAT_OFF  = 8'h0C;
   localparam logic [7:0]      IRQ_EN_OFF    = 8'h10;
   localparam logic [7:0]      IRQ_CLR_OFF   = 8'h14;
   localparam logic [1:0]      MEM_PAGE      = 2'h1;
   localparam int              START_BIT     = 0;
   localparam int              CONT_BIT      = 1;
   localparam int              IRQ_HALT      = 0;
   localparam int              IRQ_DONE      = 1;
   localparam int              IRQ_ABORT     = 2;
   localparam logic [11:0]     OFFSET_RESET  = 12'h000;
   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      CDCAL_IDLE, CDCAL_FINE, CDCAL_HALT, CDCAL_PREP,
      CDCAL_NORM, CDCAL_SEARCH, CDCAL_SEND
   } cdcal_state_e;
   typedef enum logic [1:0] {TX_IDLE, TX_CHECK, TX_GAP_ST} cdcal_tx_e;
endpackage

/* File: tb/cdcal_core_sva.sv */
// Purpose: Port checks of the coarse delay calibration core.
// Assumes: One clock, reset active low.
// Notes:   Bound into every cdcal_core instance.
`timescale 1ns/1ps
module cdcal_core_sva
   import cdcal_pkg::*;
#(
   parameter int ABORT_LIMIT = ABORT_CYCLES
) (
   // Clock and reset.
   input wire logic              pclk,
   input wire logic              presetn,
   // APB.
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [7:0]        paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   // Fine pass and delay pins.
   input wire logic              fine_start,
   input wire logic              dly_strobe,
   input wire logic [3:0]        dly_chan,
   input wire logic [OUT_W-1:0]  dly_value
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========================================================
   // Sequences
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_gap;
      !dly_strobe [*4];
   endsequence
   // ==========================================================
   // Assertions
   a_ready_after_setup: assert property (s_setup |=> pready) else $error("pready late");
   a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready held");
   a_ready_in_access: assert property (pready |-> psel && penable) else $error("stray pready");
   a_err_reads_zero: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error read not zero");
   a_start_pulse: assert property (fine_start |=> !fine_start) else $error("start too long");
   a_start_cause: assert property (fine_start |-> $past(psel && penable && pwrite
      && paddr == CTRL_OFF && pwdata[START_BIT], 2)) else $error("start without write");
   a_strobe_gap: assert property (dly_strobe |=> s_gap) else $error("strobes too close");
   a_strobe_chan: assert property (dly_strobe |-> dly_chan < 4'(NCH))
      else $error("bad channel");
   a_dly_hold: assert property (!dly_strobe |-> $stable(dly_chan) && $stable(dly_value))
      else $error("delay pins moved");
endmodule // cdcal_core_sva

bind cdcal_core cdcal_core_sva #(.ABORT_LIMIT(ABORT_LIMIT)) u_sva (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .fine_start(fine_start), .dly_strobe(dly_strobe), .dly_chan(dly_chan),
   .dly_value(dly_value));

/* File: tb/cdcal_core_tb_top.sv */
// Purpose: Self-checking bench of the coarse delay calibration core.
// Assumes: Abort limit shortened to 64 cycles.
// Notes:   The fine pass is driven by hand.
`timescale 1ns/1ps
module cdcal_core_tb_top;
   import cdcal_pkg::*;
   localparam int LIM = 64;
   logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, errv;
   logic [7:0]       paddr;
   logic [31:0]      pwdata, prdata, rdv;
   logic             fine_start, fine_wr, fine_done, dly_strobe, dly_busy, irq;
   logic [3:0]       fine_chan, dly_chan;
   logic [11:0]      fine_pos;
   logic [OUT_W-1:0] dly_value;
   int               miscompares, cmp_count;
   int               pos_a[3] = '{101, 133, 261};
   int               exp_a[3];
   cdcal_core #(.ABORT_LIMIT(LIM)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fine_start(fine_start), .fine_wr(fine_wr), .fine_chan(fine_chan),
      .fine_pos(fine_pos), .fine_done(fine_done), .dly_strobe(dly_strobe),
      .dly_chan(dly_chan), .dly_value(dly_value), .dly_busy(dly_busy), .irq(irq));
   cdcal_dly_chip_model #(.BUSY_CYC(8)) u_chip (
      .pclk(pclk), .presetn(presetn), .dly_strobe(dly_strobe), .dly_chan(dly_chan),
      .dly_value(dly_value), .dly_busy(dly_busy));
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   // ==========================================================
   // Shared tasks
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1) begin @(posedge pclk); n++; end
      chk("wait states", 32'h0, 32'(n));
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rdv & m);
   endtask
   task automatic fine_pass(input logic cont, input logic wr, input logic [11:0] pos);
      int n;
      apb(1'b1, CTRL_OFF, {30'h0, cont, 1'b1});
      n = 0;
      while (fine_start !== 1'b1) begin @(posedge pclk); n++; end
      chk("start delay", 32'd2, 32'(n));
      @(posedge pclk);
      fine_wr <= wr; fine_chan <= 4'h0; fine_pos <= pos;
      @(posedge pclk);
      fine_wr <= 1'b0; fine_done <= 1'b1;
      @(posedge pclk);
      fine_done <= 1'b0;
   endtask
   task automatic wr_entries(input logic [31:0] w0, input logic [31:0] w1,
                             input logic [31:0] w2);
      logic [31:0] w[3];
      w = '{w0, w1, w2};
      for (int i = 0; i < NCH; i++)
         apb(1'b1, 8'h40 + 8'(4 * i), (i < 3) ? w[i] : 32'h0000_1000);
   endtask
   task automatic results();
      if (miscompares == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_regs();
      rd_chk("state", STATUS_OFF, 32'h37, 32'h0);
      rd_chk("entry0", 8'h40, 32'h3FFF, 32'h1000);
      apb(1'b0, 8'hFC, 32'h0);
      chk("slverr", 32'h1, {31'h0, errv});
      chk("irq", 32'h0, {31'h0, irq});
   endtask
   task automatic t_halt();
      apb(1'b1, IRQ_EN_OFF, 32'h7);
      fine_pass(1'b0, 1'b1, 12'd100);
      repeat (3) @(posedge pclk);
      rd_chk("halt", STATUS_OFF, 32'h7, 32'h2);
      rd_chk("entry0", 8'h40, 32'h7F0FFF, {9'h0, 7'd3, 4'h0, 12'd100});
      chk("irq halt", 32'h1, {31'h0, irq});
      apb(1'b1, IRQ_CLR_OFF, 32'h1);
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      apb(1'b1, 8'h44, 32'h2123);
      rd_chk("entry1", 8'h44, 32'h3FFF, 32'h2123);
   endtask
   task automatic t_coarse_ok();
      int v[3];
      int n;
      for (int i = 0; i < 3; i++) v[i] = ((3200 - pos_a[i] + 4) ^ 31) % 2240;
      for (int k = 0; k < 70; k++) begin
         if ((v[0] == 0 || v[1] == 0 || v[2] == 0) && v[0] < 512 && v[1] < 512 && v[2] < 512)
            break;
         for (int i = 0; i < 3; i++) v[i] = (v[i] + 2208) % 2240;
      end
      for (int i = 0; i < 3; i++) exp_a[i] = v[i] % 512;
      wr_entries(32'h2000 | 32'(pos_a[0]), 32'h2000 | 32'(pos_a[1]), 32'h2000 | 32'(pos_a[2]));
      apb(1'b1, OFFSET_OFF, 32'h4);
      fine_pass(1'b1, 1'b0, 12'h0);
      n = 0;
      while (u_chip.n_rx < 3 && n < 2000) begin @(posedge pclk); n++; end
      repeat (20) @(posedge pclk);
      chk("strobes", 32'd3, 32'(u_chip.n_rx));
      for (int i = 0; i < 3; i++) chk("delay", 32'(exp_a[i]), 32'(u_chip.got[i]));
      chk("busy ignored", 32'h0, 32'(u_chip.n_err));
      rd_chk("last ok", STATUS_OFF, 32'h30, 32'h10);
      rd_chk("done flag", IRQ_STAT_OFF, 32'h2, 32'h2);
      apb(1'b1, IRQ_CLR_OFF, 32'h2);
   endtask
   task automatic t_abort();
      int n0;
      n0 = u_chip.n_rx;
      wr_entries(32'h2000 | 32'd101, 32'h2000 | 32'd1101, 32'h1000);
      apb(1'b1, IRQ_EN_OFF, 32'h0);
      fine_pass(1'b1, 1'b0, 12'h0);
      repeat (LIM + 200) @(posedge pclk);
      chk("no strobes", 32'(n0), 32'(u_chip.n_rx));
      rd_chk("last abort", STATUS_OFF, 32'h30, 32'h20);
      rd_chk("abort flag", IRQ_STAT_OFF, 32'h4, 32'h4);
      chk("irq masked", 32'h0, {31'h0, irq});
   endtask
   // ==========================================================
   // Main sequence and watchdog
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
      pwdata = 32'h0; fine_wr = 1'b0; fine_done = 1'b0; fine_chan = 4'h0; fine_pos = 12'h0;
      miscompares = 0;
      cmp_count = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_halt();
      t_coarse_ok();
      t_abort();
      results();
   end
   initial begin
      #300us;
      miscompares++;
      results();
   end
endmodule // cdcal_core_tb_top

/* File: tb/cdcal_dly_chip_model.sv */
// Purpose: Model of the external per-fibre delay chips.
// Assumes: Busy rises after each strobe for BUSY_CYC cycles.
// Notes:   Counts strobes that arrive while busy.
`timescale 1ns/1ps
module cdcal_dly_chip_model
   import cdcal_pkg::*;
#(
   parameter int BUSY_CYC = 8
) (
   // Clock and reset.
   input wire logic              pclk,
   input wire logic              presetn,
   // Delay pins.
   input wire logic              dly_strobe,
   input wire logic [3:0]        dly_chan,
   input wire logic [OUT_W-1:0]  dly_value,
   output logic                  dly_busy
);
   logic [OUT_W-1:0] got [NCH];
   int               n_rx;
   int               n_err;
   int               busy_cnt;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         n_rx     <= 0;
         n_err    <= 0;
         busy_cnt <= 0;
      end else if (dly_strobe) begin
         got[dly_chan] <= dly_value;
         n_rx          <= n_rx + 1;
         n_err         <= n_err + int'(dly_busy);
         busy_cnt      <= BUSY_CYC;
      end else if (busy_cnt > 0) begin
         busy_cnt <= busy_cnt - 1;
      end
   end
   assign dly_busy = busy_cnt != 0;
endmodule // cdcal_dly_chip_model
